//--- pwmt_top.v
// eight-channel pulse width timer with an AHB-Lite register slave
// assumes a single master, single word transfers; outputs go to external circuitry
//
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "pwmt_consts.vh"

// Operation
// - eight channels, each with own 16-bit counter and 8-bit period and duty
// - duty selectable from always inactive to always active
// - pulse-code mode selectable per channel instead of plain modulation
// - per-channel selectable output polarity
// - per-channel edge-aligned or centre-aligned pulses
// - pairs 7:6, 5:4, 3:2, 1:0 may join into 16-bit channels
module pwmt_top (
    input  wire        CLOCK,
    input  wire        RSTN,
    input  wire        HSEL,
    input  wire [31:0] HADDR,
    input  wire [1:0]  HTRANS,
    input  wire        HWRITE,
    input  wire [2:0]  HSIZE,
    input  wire [31:0] HWDATA,
    input  wire        HREADY,
    output wire [31:0] HRDATA,
    output wire        HREADYOUT,
    output wire        HRESP,
    output wire [7:0]  PWM_OUT
);

    localparam NCH = `PWMT_NUM_CH;
    localparam CW  = `PWMT_CH_W;

    reg  [7:0]    en_r;
    reg  [7:0]    pol_r;
    reg  [7:0]    align_r;
    reg  [3:0]    cat_r;
    reg  [7:0]    pcm_r;
    reg  [7:0]    pre_r;
    reg  [CW-1:0] per_r [0:NCH-1];
    reg  [CW-1:0] dut_r [0:NCH-1];
    reg  [7:0]    div_r;
    reg           tick_r;
    reg           wr_pend_r;
    reg           rd_pend_r;
    reg  [7:0]    addr_r;
    reg           hready_r;
    reg  [31:0]   rdata_r;
    reg  [31:0]   rd_mux;
    wire [8*NCH-1:0]  cnt_rd;
    wire [16*NCH-1:0] cnt_all;
    wire              accept;
    wire              in_map;
    integer           k;
    integer           m;

    assign HRDATA    = rdata_r;
    assign HREADYOUT = hready_r;
    assign HRESP     = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // prescaler: one-cycle tick every pre_r+1 clocks

    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            div_r  <= 8'h00;
            tick_r <= 1'b0;
        end else if (div_r >= pre_r) begin
            div_r  <= 8'h00;
            tick_r <= 1'b1;
        end else begin
            div_r  <= div_r + 8'h01;
            tick_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // channels

    genvar i;
    generate
        for (i = 0; i < NCH; i = i + 1) begin : g_ch
            localparam LO = i - (i % 2);
            localparam HI = LO + 1;
            wire        cat  = cat_r[i/2];
            wire        lo_j = cat && (i % 2 == 0);
            wire [15:0] per  = (cat && i % 2 == 1) ? {per_r[HI], per_r[LO]} : {8'h00, per_r[i]};
            wire [15:0] dut  = (cat && i % 2 == 1) ? {dut_r[HI], dut_r[LO]} : {8'h00, dut_r[i]};
            wire [15:0] cnt  = cnt_all[16*i +: 16];
            wire [15:0] cnth = cnt_all[16*HI +: 16];

            // low half of a joined pair stays idle at its inactive level
            pwmt_chan #(.W(16)) u_chan (
                .clk    (CLOCK),
                .rstn   (RSTN),
                .tick   (tick_r),
                .en     (en_r[i] & ~lo_j),
                .center (align_r[i]),
                .pcm    (pcm_r[i]),
                .pol    (pol_r[i]),
                .period (per),
                .duty   (dut),
                .cnt_o  (cnt_all[16*i +: 16]),
                .out_o  (PWM_OUT[i])
            );

            assign cnt_rd[8*i +: 8] = !cat ? cnt[7:0] : ((i % 2 == 1) ? cnth[15:8] : cnth[7:0]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: writes zero wait, reads one wait state

    assign accept = HSEL && HTRANS[1] && HREADY;
    assign in_map = (HADDR[31:8] == 24'h000000) && (HADDR[7:0] < `PWMT_OFS_LIMIT);

    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r    <= 8'h00;
            hready_r  <= 1'b1;
            rdata_r   <= 32'h00000000;
        end else begin
            wr_pend_r <= 1'b0;
            if (rd_pend_r) begin
                rd_pend_r <= 1'b0;
                hready_r  <= 1'b1;
                rdata_r   <= rd_mux;
            end else if (accept) begin
                addr_r    <= in_map ? {HADDR[7:2], 2'b00} : 8'hFF;
                wr_pend_r <= HWRITE;
                rd_pend_r <= ~HWRITE;
                hready_r  <= HWRITE;
            end
        end
    end

    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            en_r    <= `PWMT_RST_ENABLE;
            pol_r   <= `PWMT_RST_POLAR;
            align_r <= `PWMT_RST_ALIGN;
            cat_r   <= `PWMT_RST_CONCAT;
            pcm_r   <= `PWMT_RST_PCM;
            pre_r   <= `PWMT_RST_PRESCALE;
            for (k = 0; k < NCH; k = k + 1) begin
                per_r[k] <= `PWMT_RST_PERIOD;
                dut_r[k] <= `PWMT_RST_DUTY;
            end
        end else if (wr_pend_r) begin
            case (addr_r)
                `PWMT_OFS_ENABLE:   en_r    <= HWDATA[7:0];
                `PWMT_OFS_POLAR:    pol_r   <= HWDATA[7:0];
                `PWMT_OFS_ALIGN:    align_r <= HWDATA[7:0];
                `PWMT_OFS_CONCAT:   cat_r   <= HWDATA[3:0];
                `PWMT_OFS_PCM:      pcm_r   <= HWDATA[7:0];
                `PWMT_OFS_PRESCALE: pre_r   <= HWDATA[7:0];
                default: begin
                    for (k = 0; k < NCH; k = k + 1) begin
                        if (addr_r == `PWMT_OFS_PERIOD + 4 * k)
                            per_r[k] <= HWDATA[CW-1:0];
                        if (addr_r == `PWMT_OFS_DUTY + 4 * k)
                            dut_r[k] <= HWDATA[CW-1:0];
                    end
                end
            endcase
        end
    end

    always @* begin
        rd_mux = 32'h00000000;
        case (addr_r)
            `PWMT_OFS_ENABLE:   rd_mux = {24'h000000, en_r};
            `PWMT_OFS_POLAR:    rd_mux = {24'h000000, pol_r};
            `PWMT_OFS_ALIGN:    rd_mux = {24'h000000, align_r};
            `PWMT_OFS_CONCAT:   rd_mux = {28'h0000000, cat_r};
            `PWMT_OFS_PCM:      rd_mux = {24'h000000, pcm_r};
            `PWMT_OFS_PRESCALE: rd_mux = {24'h000000, pre_r};
            default: begin
                for (m = 0; m < NCH; m = m + 1) begin
                    if (addr_r == `PWMT_OFS_PERIOD + 4 * m)
                        rd_mux = {24'h000000, per_r[m]};
                    if (addr_r == `PWMT_OFS_DUTY + 4 * m)
                        rd_mux = {24'h000000, dut_r[m]};
                    if (addr_r == `PWMT_OFS_COUNT + 4 * m)
                        rd_mux = {24'h000000, cnt_rd[8*m +: 8]};
                end
            end
        endcase
    end

endmodule

//--- pwmt_consts.vh
// register map, reset values and field limits of the eight-channel pulse width timer
// assumes a 32-bit AHB-Lite register port, word aligned accesses only
`ifndef PWMT_CONSTS_VH
`define PWMT_CONSTS_VH

`define PWMT_OFS_ENABLE   8'h00
`define PWMT_OFS_POLAR    8'h04
`define PWMT_OFS_ALIGN    8'h08
`define PWMT_OFS_CONCAT   8'h0C
`define PWMT_OFS_PCM      8'h10
`define PWMT_OFS_PRESCALE 8'h14
`define PWMT_OFS_PERIOD   8'h20
`define PWMT_OFS_DUTY     8'h40
`define PWMT_OFS_COUNT    8'h60
`define PWMT_OFS_LIMIT    8'h80

`define PWMT_RST_ENABLE   8'h00
`define PWMT_RST_POLAR    8'hFF
`define PWMT_RST_ALIGN    8'h00
`define PWMT_RST_CONCAT   4'h0
`define PWMT_RST_PCM      8'h00
`define PWMT_RST_PRESCALE 8'h00
`define PWMT_RST_PERIOD   8'hFF
`define PWMT_RST_DUTY     8'h00

`define PWMT_NUM_CH       8
`define PWMT_CH_W         8

`endif

//--- pwmt_chan.v
// one modulation channel: counter, compare, centre and pcm modes, polarity
// assumes period and duty are held stable by the register block, tick is a one-cycle enable
`timescale 1ns/100ps

module pwmt_chan #(
    parameter W = 16
) (
    input  wire         clk,
    input  wire         rstn,
    input  wire         tick,
    input  wire         en,
    input  wire         center,
    input  wire         pcm,
    input  wire         pol,
    input  wire [W-1:0] period,
    input  wire [W-1:0] duty,
    output wire [W-1:0] cnt_o,
    output wire         out_o
);

    reg  [W-1:0] cnt_r;
    reg          dir_r;
    reg  [W-1:0] acc_r;
    reg          out_r;
    wire [W-1:0] one  = {{(W-1){1'b0}}, 1'b1};
    wire [W-1:0] dlim = (duty > period) ? period : duty;
    wire [W:0]   sum  = {1'b0, acc_r} + {1'b0, dlim};
    wire [W-1:0] inc  = cnt_r + one;
    wire         act_cmp = (cnt_r < duty);
    wire         act_pcm = (sum >= {1'b0, period}) && (dlim != {W{1'b0}});

    assign cnt_o = cnt_r;
    assign out_o = out_r;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= {W{1'b0}};
            dir_r <= 1'b0;
            acc_r <= {W{1'b0}};
            out_r <= 1'b0;
        end else if (!en) begin
            cnt_r <= {W{1'b0}};
            dir_r <= 1'b0;
            acc_r <= {W{1'b0}};
            out_r <= ~pol;
        end else if (tick) begin
            if (pcm) begin
                // first order noise shaping spreads the active time evenly
                if (act_pcm)
                    acc_r <= sum[W-1:0] - period;
                else if (period != {W{1'b0}})
                    acc_r <= sum[W-1:0];
                out_r <= act_pcm ^ ~pol;
            end else begin
                if (center) begin
                    // up to period then back down: pulse symmetric about zero
                    if (!dir_r) begin
                        if (cnt_r >= period) begin
                            // a period of one or zero must not spend an extra tick at zero
                            dir_r <= (cnt_r > one);
                            cnt_r <= (cnt_r == {W{1'b0}}) ? cnt_r : cnt_r - one;
                        end else begin
                            cnt_r <= inc;
                        end
                    end else begin
                        if (cnt_r <= one)
                            dir_r <= 1'b0;
                        cnt_r <= (cnt_r == {W{1'b0}}) ? cnt_r : cnt_r - one;
                    end
                end else begin
                    cnt_r <= (inc >= period) ? {W{1'b0}} : inc;
                end
                out_r <= act_cmp ^ ~pol;
            end
        end
    end

endmodule

//--- pwmt_monitor.sv
// checker for the pulse width timer top ports: bus timing and idle output levels
// assumes one bus master, HREADY fed back from HREADYOUT
`timescale 1ns/100ps
module pwmt_monitor (
    input wire        CLOCK,
    input wire        RSTN,
    input wire        HSEL,
    input wire [31:0] HADDR,
    input wire [1:0]  HTRANS,
    input wire        HWRITE,
    input wire [31:0] HWDATA,
    input wire        HREADY,
    input wire [31:0] HRDATA,
    input wire        HREADYOUT,
    input wire        HRESP,
    input wire [7:0]  PWM_OUT
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    wire       take = HSEL & HTRANS[1] & HREADY;
    reg        wr_r;
    reg  [7:0] a_r;
    reg  [7:0] en_r;
    reg  [7:0] pol_r;
    reg  [3:0] cat_r;
    reg  [9:0] quiet_r;
    // outputs that must sit inactive: disabled, or even half of a joined pair
    wire [7:0] idle = ~en_r | {1'b0, cat_r[3], 1'b0, cat_r[2], 1'b0, cat_r[1], 1'b0, cat_r[0]};
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            wr_r    <= 1'b0;
            a_r     <= 8'h00;
            en_r    <= 8'h00;
            pol_r   <= 8'hFF;
            cat_r   <= 4'h0;
            quiet_r <= 10'h000;
        end else begin
            wr_r <= take & HWRITE & ~|HADDR[31:8];
            if (take)
                a_r <= HADDR[7:0];
            if (wr_r && a_r < 8'h10)
                quiet_r <= 10'h000;
            else if (quiet_r != 10'h3FF)
                quiet_r <= quiet_r + 10'h001;
            if (wr_r && a_r == 8'h00)
                en_r <= HWDATA[7:0];
            if (wr_r && a_r == 8'h04)
                pol_r <= HWDATA[7:0];
            if (wr_r && a_r == 8'h0C)
                cat_r <= HWDATA[3:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_one_wait;
        !HREADYOUT ##1 HREADYOUT;
    endsequence
    AST_READ_WAIT: assert property (take && !HWRITE |=> s_one_wait) else $error("read wait not one cycle");
    AST_WRITE_NOWAIT: assert property (take && HWRITE |=> HREADYOUT) else $error("write stalled");
    AST_RESP_OKAY: assert property (HRESP == 1'b0) else $error("response not okay");
    AST_COUNT_BYTE: assert property (take && !HWRITE && HADDR[7:5] == 3'h3 |=> ##1 HRDATA[31:8] == 24'h0)
        else $error("counter wider than a byte");
    AST_UNMAPPED: assert property (take && !HWRITE && HADDR[31:8] != 24'h0 |=> ##1 HRDATA == 32'h0)
        else $error("unmapped read not zero");
    AST_HOLD_RDATA: assert property (HREADYOUT |=> $stable(HRDATA)) else $error("read data moved");
    AST_IDLE_LEVEL: assert property (quiet_r >= 10'h258 |-> ((PWM_OUT ^ ~pol_r) & idle) == 8'h00)
        else $error("idle output not at inactive level");
endmodule

//--- pwmt_load.sv
// external load on the modulated outputs: counts high cycles per channel
// assumes meas changes just after a rising clock edge
`timescale 1ns/100ps
module pwmt_load (
    input  wire       clk,
    input  wire       meas,
    input  wire [7:0] pwm,
    output integer    hi [8]
);
    always @(posedge clk) begin
        for (int i = 0; i < 8; i++) begin
            // four-state sum so an unknown output level shows up as a mismatch
            hi[i] <= meas ? hi[i] + pwm[i] : 0;
        end
    end
endmodule

//--- tb.sv
// bench for the pulse width timer: bus tasks, reference model, duty measurement
// assumes one slave, HREADY fed back from HREADYOUT
`timescale 1ns/100ps
module tb;
    logic        CLOCK = 0;
    logic        RSTN = 0;
    logic        meas = 0;
    logic        hwrite = 0;
    logic [1:0]  htrans = 0;
    logic [31:0] haddr = 0;
    logic [31:0] hwdata = 0;
    logic [31:0] q;
    logic [31:0] HRDATA;
    logic        HREADYOUT;
    logic        HRESP;
    logic [7:0]  PWM_OUT;
    integer      hi [8];
    int          mdl [32];
    int          dtab [8] = '{0, 1, 2, 3, 4, 5, 7, 8};
    int          win [5] = '{64, 128, 64, 64, 256};
    int          miscompares = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          seed = 32'h365020d9;
    // per row: enable, polarity, align, join, pcm, prescale
    bit   [47:0] sc [5] = '{48'hFF_FF_00_00_00_00, 48'hFF_00_00_00_00_01, 48'h7F_FF_FF_00_00_00,
                           48'hFF_A5_00_00_FF_00, 48'hFF_FF_00_0F_00_00};
    always #4 CLOCK = ~CLOCK;
    pwmt_top uut (.CLOCK(CLOCK), .RSTN(RSTN), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
                  .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
                  .HRESP(HRESP), .PWM_OUT(PWM_OUT));
    pwmt_load load (.clk(CLOCK), .meas(meas), .pwm(PWM_OUT), .hi(hi));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int i;
        i = a >> 2;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
        q = HRDATA;
        if (wr && (i < 6 || i inside {[8:23]}))
            mdl[i] = d & (i == 3 ? 15 : 255);
    endtask
    task automatic rd(input int i);
        bus(1'b0, i * 4, 0);
        chk(q, mdl[i]);
    endtask
    // high clocks of channel c over a window of w clocks
    function automatic int expect_hi(int c, int w);
        int j, b, p, d, a;
        j = (mdl[3] >> (c / 2)) & 1;
        b = j ? (c | 1) : c;
        p = j ? mdl[8 + b] * 256 + mdl[7 + b] : mdl[8 + c];
        d = j ? mdl[16 + b] * 256 + mdl[15 + b] : mdl[16 + c];
        if (mdl[2] >> b & 1)
            a = d == 0 ? 0 : d > p ? w : (2 * d - 1) * w / (2 * p);
        else
            a = (d >= p ? p : d) * w / p;
        if (!(mdl[0] >> b & 1) || (j && !(c & 1)))
            a = 0;
        return (mdl[1] >> b & 1) ? a : w - a;
    endfunction
    task automatic tally_and_finish();
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 32; i++)
            mdl[i] = (i == 1 || i inside {[8:15]}) ? 255 : 0;
        repeat (12) @(posedge CLOCK);
        RSTN <= 1'b1;
        for (int i = 0; i < 32; i++)
            rd(i);
        bus(1'b0, 32'h100, 0);
        chk(q, 0);
        for (int i = 0; i < 24; i++) begin
            bus(1'b1, i * 4, $random(seed));
            rd(i);
        end
        for (int r = 0; r < 5; r++) begin
            bus(1'b1, 0, 0);
            for (int c = 0; c < 8; c++) begin
                bus(1'b1, 32 + 4 * c, r == 4 ? c & 1 : 8);
                bus(1'b1, 64 + 4 * c, r == 4 ? (c & 1 ? 0 : 32 * c) : dtab[c]);
            end
            for (int i = 5; i >= 0; i--)
                bus(1'b1, 4 * i, sc[r][47 - 8 * i -: 8]);
            repeat (600) @(posedge CLOCK);
            meas <= 1'b1;
            repeat (win[r]) @(posedge CLOCK);
            meas <= 1'b0;
            #1;
            for (int c = 0; c < 8; c++)
                chk(hi[c], expect_hi(c, win[r]));
            @(posedge CLOCK);
        end
        bus(1'b1, 0, 0);
        repeat (600) @(posedge CLOCK);
        for (int i = 24; i < 32; i++)
            rd(i);
        tally_and_finish();
    end
    always @(posedge CLOCK) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            miscompares++;
            tally_and_finish();
        end
    end
endmodule
bind pwmt_top pwmt_monitor chk_i (.CLOCK(CLOCK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .PWM_OUT(PWM_OUT));
